// ===== rtl/srr_status_regs.sv
/*
 Status reporting registers of a bench instrument's remote interface:
 questionable data event/enable, standard event and enable, status byte
 enable, serial poll request flag, power-on clear setting and error queue.
 Assumes a command parser on the same clock that issues one command pulse
 at a time, only after all earlier commands finished, and measurement logic
 that raises one-cycle event pulses on the same clock. The non-volatile
 store keeps the power-on clear setting and presents it at i_psc_nv.
 The reset input stands for the power cycle. The enable masks of the status
 byte and standard event registers carry no reset: they keep their contents
 across it unless the stored setting asks for a clear in the capture cycle.
 The parser must not issue a command while reset is held or in that cycle.
 Error text arrives as one wide word; a push into a full queue is lost, so
 the source must watch o_err_full before pushing. Operation complete is
 only signalled once the parser holds back later commands.
*/
//
// How it works
// (RQ1) Voltage-class overload sets questionable bit 0
// (RQ2) Current overload sets questionable bit 1
// (RQ3) Resistance overload sets questionable bit 9
// (RQ4) Low limit failure sets bit 11
// (RQ5) High limit failure sets bit 12
// (RQ6) Unassigned questionable bits stay and read zero
// (RQ7) Clear-status or event query clears questionable events
// (RQ8) Questionable enable cleared: power-on, preset, zero write
// (RQ9) Standard enable cleared on zero or power-on clear
// (RQ10) Questionable summary from enabled event bits
// (RQ11) Twenty-entry FIFO error queue, eighty characters
// (RQ12) Queries return binary-weighted register value
// (RQ13) Clear-status clears summary and all events
// (RQ14) Standard enable loaded by its enable command
// (RQ15) Operation complete command sets standard bit 0
// (RQ16) Operation complete query answers value one
// (RQ17) Power-on clear setting kept and queried
// (RQ18) Status byte enable loaded by its command
// (RQ19) Status byte query leaves request bit intact
// (RQ20) Questionable enable loaded by its command
// (RQ21) Enabled summaries raise request; poll clears it
`timescale 1ns/1ps
`include "srr_defs.svh"

module srr_status_regs
    import srr_pkg::*;
#(
    parameter int ERR_DEPTH = `SRR_ERRQ_DEPTH,
    parameter int ERR_CHARS = `SRR_ERR_CHARS
) (
    input  wire logic                   i_mclk,
    input  wire logic                   i_reset,
    input  wire logic                   i_cmd_valid,
    input  wire srr_cmd_e               i_cmd,
    input  wire logic [15:0]            i_cmd_data,
    input  wire logic                   i_psc_nv,
    input  wire logic                   i_ovl_volt,
    input  wire logic                   i_ovl_curr,
    input  wire logic                   i_ovl_ohms,
    input  wire logic                   i_limit_on,
    input  wire logic                   i_lim_lo,
    input  wire logic                   i_lim_hi,
    input  wire logic [7:0]             i_std_events,
    input  wire logic                   i_mav,
    input  wire logic                   i_serial_poll,
    input  wire logic                   i_err_push,
    input  wire logic [ERR_CHARS*8-1:0] i_err_text,
    input  wire logic                   i_err_pop,
    output logic                        o_rsp_valid,
    output logic [15:0]                 o_rsp_data,
    output logic                        o_psc_wr,
    output logic                        o_psc_wr_data,
    output logic [7:0]                  o_status_byte,
    output logic                        o_srq,
    output logic                        o_err_valid,
    output logic [ERR_CHARS*8-1:0]      o_err_text,
    output logic                        o_err_full
);

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    function automatic logic is_cmd(input srr_cmd_e c);
        is_cmd = i_cmd_valid && (i_cmd == c);
    endfunction : is_cmd

    function automatic logic [15:0] qd_keep(input logic [15:0] v);
        qd_keep = v & `SRR_QD_USED_MASK; // RQ6
    endfunction : qd_keep

    function automatic logic [7:0] se_keep(input logic [7:0] v);
        se_keep = v & `SRR_SE_USED_MASK;
    endfunction : se_keep

    logic        cls;
    logic        qev_rd;
    logic        esr_rd;
    logic        poweron_reg;
    logic [15:0] qev_reg;
    logic [15:0] qen_reg;
    logic [7:0]  sev_reg;
    logic [7:0]  sen_reg;
    logic [7:0]  sre_reg;
    logic        psc_reg;
    logic        rqs_reg;
    logic [15:0] qd_set;
    logic [7:0]  sb_sum;
    logic [7:0]  sb_now;
    logic        sb_req;
    logic        sb_req_d;

    assign cls    = is_cmd(SRR_CMD_CLS);
    assign qev_rd = is_cmd(SRR_CMD_QEV_RD);
    assign esr_rd = is_cmd(SRR_CMD_ESR_RD);

    // ------------------------------------------------------------------
    // Power-on strap capture
    // ------------------------------------------------------------------
    // Setting is read after release so the reset never loads a port value
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            poweron_reg <= 1'b1;
        end else begin
            poweron_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            psc_reg <= 1'b0;
        end else if (poweron_reg) begin
            psc_reg <= i_psc_nv; // RQ17
        end else if (is_cmd(SRR_CMD_PSC_WR)) begin
            psc_reg <= i_cmd_data[0]; // RQ17
        end
    end

    assign o_psc_wr      = is_cmd(SRR_CMD_PSC_WR); // RQ17
    assign o_psc_wr_data = i_cmd_data[0];

    // ------------------------------------------------------------------
    // Questionable data
    // ------------------------------------------------------------------
    // Limit results count only while limit testing runs
    always_comb begin
        qd_set = 16'h0000;
        qd_set[`SRR_QD_VOLT_BIT]  = i_ovl_volt; // RQ1
        qd_set[`SRR_QD_CURR_BIT]  = i_ovl_curr; // RQ2
        qd_set[`SRR_QD_OHMS_BIT]  = i_ovl_ohms; // RQ3
        qd_set[`SRR_QD_LIMLO_BIT] = i_limit_on && i_lim_lo; // RQ4
        qd_set[`SRR_QD_LIMHI_BIT] = i_limit_on && i_lim_hi; // RQ5
    end

    // New events win over a clearing query in the same cycle
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            qev_reg <= 16'h0000;
        end else if (cls || qev_rd) begin
            qev_reg <= qd_set; // RQ7
        end else begin
            qev_reg <= qd_keep(qev_reg | qd_set); // RQ6
        end
    end

    // Power-on clear always applies here, unlike the other masks
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            qen_reg <= 16'h0000; // RQ8
        end else if (is_cmd(SRR_CMD_PRESET)) begin
            qen_reg <= 16'h0000; // RQ8
        end else if (is_cmd(SRR_CMD_QEN_WR)) begin
            qen_reg <= qd_keep(i_cmd_data); // RQ20 RQ8 RQ6
        end
    end

    // ------------------------------------------------------------------
    // Standard event register
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            sev_reg <= 8'h00;
        end else if (cls || esr_rd) begin
            sev_reg <= se_keep(i_std_events); // RQ13
        end else begin
            sev_reg <= se_keep(sev_reg | i_std_events
                               | {7'h00, is_cmd(SRR_CMD_OPC)}); // RQ15
        end
    end

    // ------------------------------------------------------------------
    // Enable masks
    // ------------------------------------------------------------------
    // No reset term: a power cycle keeps the masks unless the stored
    // setting asks for a clear. Until the first clear or write their
    // contents are undefined, so the first power-on should clear them.
    always_ff @(posedge i_mclk) begin
        if (poweron_reg && i_psc_nv) begin
            sen_reg <= 8'h00; // RQ9
        end else if (is_cmd(SRR_CMD_ESE_WR)) begin
            sen_reg <= i_cmd_data[7:0]; // RQ14 RQ9
        end
    end

    // Same power-on rule; the request bit itself can never be enabled
    always_ff @(posedge i_mclk) begin
        if (poweron_reg && i_psc_nv) begin
            sre_reg <= 8'h00;
        end else if (is_cmd(SRR_CMD_SRE_WR)) begin
            sre_reg <= i_cmd_data[7:0] & ~(8'h01 << `SRR_SB_RQS_BIT); // RQ18
        end
    end

    // ------------------------------------------------------------------
    // Status byte and service request
    // ------------------------------------------------------------------
    always_comb begin
        sb_sum = 8'h00;
        sb_sum[`SRR_SB_EAV_BIT] = o_err_valid;
        sb_sum[`SRR_SB_QSB_BIT] = |(qev_reg & qen_reg); // RQ10
        sb_sum[`SRR_SB_MAV_BIT] = i_mav;
        sb_sum[`SRR_SB_ESB_BIT] = |(sev_reg & sen_reg); // RQ14
    end

    // Poll and query see one value; the poll clears the request, the query never does
    assign sb_now = sb_sum | {1'b0, rqs_reg, 6'h00}; // RQ19

    // ------------------------------------------------------------------
    // Service request
    // ------------------------------------------------------------------
    assign sb_req = |(sb_sum & sre_reg);

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            sb_req_d <= 1'b0;
        end else begin
            sb_req_d <= sb_req;
        end
    end

    // Request is raised on a new enabled summary; a rising summary wins
    // A poll in that same cycle therefore leaves the request standing
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            rqs_reg <= 1'b0;
        end else if (sb_req && !sb_req_d) begin
            rqs_reg <= 1'b1; // RQ21
        end else if (i_serial_poll || cls || !sb_req) begin
            rqs_reg <= 1'b0; // RQ21 RQ13
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_status_byte <= 8'h00;
        end else begin
            o_status_byte <= sb_now;
        end
    end

    assign o_srq = rqs_reg; // RQ21

    // ------------------------------------------------------------------
    // Query answers
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_rsp_valid <= 1'b0;
            o_rsp_data  <= 16'h0000;
        end else begin
            o_rsp_valid <= 1'b1;
            unique case (i_cmd_valid ? i_cmd : SRR_CMD_NONE)
                SRR_CMD_QEV_RD: o_rsp_data <= qev_reg; // RQ12 RQ6
                SRR_CMD_QEN_RD: o_rsp_data <= qen_reg; // RQ12
                SRR_CMD_ESR_RD: o_rsp_data <= {8'h00, sev_reg}; // RQ12
                SRR_CMD_ESE_RD: o_rsp_data <= {8'h00, sen_reg}; // RQ12
                SRR_CMD_SRE_RD: o_rsp_data <= {8'h00, sre_reg}; // RQ12
                SRR_CMD_STB_RD: o_rsp_data <= {8'h00, sb_now}; // RQ19
                SRR_CMD_PSC_RD: o_rsp_data <= {15'h0000, psc_reg}; // RQ17
                SRR_CMD_OPC_RD: o_rsp_data <= 16'h0001; // RQ16
                default: begin
                    o_rsp_valid <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Error queue
    // ------------------------------------------------------------------
    // Storage is wide flops; a full queue drops the newest error
    localparam int PW = $clog2(ERR_DEPTH);
    logic [ERR_CHARS*8-1:0] err_mem [ERR_DEPTH];
    logic [PW-1:0]          wr_ptr_reg;
    logic [PW-1:0]          rd_ptr_reg;
    logic [PW:0]            count_reg;
    logic                   do_push;
    logic                   do_pop;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(ERR_DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    assign o_err_full = (count_reg == (PW+1)'(ERR_DEPTH));
    assign do_push    = i_err_push && !o_err_full;
    assign do_pop     = i_err_pop && o_err_valid;

    // ------------------------------------------------------------------
    // Error queue storage
    // ------------------------------------------------------------------
    // Entry text is taken on pop, so the reader sees it a cycle later
    always_ff @(posedge i_mclk) begin
        if (do_push) begin
            err_mem[wr_ptr_reg] <= i_err_text; // RQ11
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            end
            if (do_pop) begin
                rd_ptr_reg <= ptr_inc(rd_ptr_reg); // RQ11
            end
            count_reg <= count_reg + (PW+1)'(do_push) - (PW+1)'(do_pop);
        end
    end

    assign o_err_valid = (count_reg != '0);

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_err_text <= '0;
        end else if (do_pop) begin
            o_err_text <= err_mem[rd_ptr_reg]; // RQ11
        end
    end

endmodule : srr_status_regs

// ===== shared/srr_defs.svh
/*
 Timing-free constants of the status reporting block: bit positions, used-bit masks,
 queue sizes. Assumes inclusion by bare name.
*/
`ifndef SRR_DEFS_SVH
`define SRR_DEFS_SVH

`define SRR_QD_VOLT_BIT      0
`define SRR_QD_CURR_BIT      1
`define SRR_QD_OHMS_BIT      9
`define SRR_QD_LIMLO_BIT     11
`define SRR_QD_LIMHI_BIT     12
`define SRR_QD_USED_MASK     16'h1a03
`define SRR_SE_OPC_BIT       0
`define SRR_SE_USED_MASK     8'hbd
`define SRR_SB_EAV_BIT       2
`define SRR_SB_QSB_BIT       3
`define SRR_SB_MAV_BIT       4
`define SRR_SB_ESB_BIT       5
`define SRR_SB_RQS_BIT       6
`define SRR_ERRQ_DEPTH       20
`define SRR_ERR_CHARS        80

`endif

// ===== shared/srr_pkg.sv
/*
 Types of the status reporting block: command codes.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package srr_pkg;
    typedef enum logic [3:0] {
        SRR_CMD_NONE,
        SRR_CMD_CLS,
        SRR_CMD_ESE_WR,
        SRR_CMD_ESE_RD,
        SRR_CMD_ESR_RD,
        SRR_CMD_OPC,
        SRR_CMD_OPC_RD,
        SRR_CMD_PSC_WR,
        SRR_CMD_PSC_RD,
        SRR_CMD_SRE_WR,
        SRR_CMD_SRE_RD,
        SRR_CMD_STB_RD,
        SRR_CMD_QEN_WR,
        SRR_CMD_QEN_RD,
        SRR_CMD_QEV_RD,
        SRR_CMD_PRESET
    } srr_cmd_e;
endpackage : srr_pkg

// ===== verif/srr_ctl_model.sv
/*
 Remote controller model: issues one status command at a time.
 Assumes the bench calls send from one process only.
*/
`timescale 1ns/1ps
module srr_ctl_model
    import srr_pkg::*;
(
    input  wire logic   i_mclk,
    output srr_cmd_e    o_cmd,
    output logic        o_cmd_valid,
    output logic [15:0] o_cmd_data
);
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd       = SRR_CMD_NONE;
        o_cmd_data  = 16'h0000;
    end
    // One-cycle strobe, then a gap cycle so two commands never merge
    task send(input srr_cmd_e c, input logic [15:0] d);
        @(negedge i_mclk);
        o_cmd_valid = 1'b1;
        o_cmd       = c;
        o_cmd_data  = d;
        @(negedge i_mclk);
        o_cmd_valid = 1'b0;
        o_cmd_data  = ~d;
        o_cmd       = SRR_CMD_NONE;
    endtask : send
endmodule : srr_ctl_model

// ===== verif/srr_status_regs_props.sv
/*
 Port checker of the status register block.
 Assumes one clock and the async reset; attached by bind.
*/
`timescale 1ns/1ps
module srr_status_regs_props
    import srr_pkg::*;
(
    input wire logic        i_mclk,
    input wire logic        i_reset,
    input wire logic        i_cmd_valid,
    input wire srr_cmd_e    i_cmd,
    input wire logic [15:0] i_cmd_data,
    input wire logic        i_serial_poll,
    input wire logic        i_ovl_volt,
    input wire logic        i_ovl_curr,
    input wire logic        i_ovl_ohms,
    input wire logic        i_lim_lo,
    input wire logic        i_lim_hi,
    input wire logic        o_rsp_valid,
    input wire logic [15:0] o_rsp_data,
    input wire logic        o_psc_wr,
    input wire logic        o_psc_wr_data,
    input wire logic        o_srq,
    input wire logic        o_err_valid,
    input wire logic        o_err_full
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    logic ev;
    assign ev = i_ovl_volt | i_ovl_curr | i_ovl_ohms | i_lim_lo | i_lim_hi;
    function automatic logic is_q(input srr_cmd_e c);
        return c inside {SRR_CMD_ESE_RD, SRR_CMD_ESR_RD, SRR_CMD_OPC_RD, SRR_CMD_PSC_RD,
                         SRR_CMD_SRE_RD, SRR_CMD_STB_RD, SRR_CMD_QEN_RD, SRR_CMD_QEV_RD};
    endfunction : is_q
    answer_next_a: assert property (i_cmd_valid && is_q(i_cmd) |=> o_rsp_valid)
        else $error("query not answered");
    answer_only_a: assert property (o_rsp_valid |-> $past(i_cmd_valid) && is_q($past(i_cmd)))
        else $error("answer without query");
    opc_one_a: assert property (i_cmd_valid && i_cmd == SRR_CMD_OPC_RD |=> o_rsp_data == 16'h0001)
        else $error("opc query not one");
    psc_store_a: assert property (i_cmd_valid && i_cmd == SRR_CMD_PSC_WR
        |-> o_psc_wr && o_psc_wr_data == i_cmd_data[0]) else $error("psc not stored");
    poll_clear_a: assert property (i_serial_poll |=> !o_srq)
        else $error("poll left request");
    qev_unused_a: assert property (o_rsp_valid && $past(i_cmd) == SRR_CMD_QEV_RD
        |-> (o_rsp_data & 16'he5fc) == 16'h0000) else $error("unused bit set");
    cls_clear_a: assert property ((i_cmd_valid && i_cmd == SRR_CMD_CLS && !ev) ##1 !ev
        ##1 (i_cmd_valid && i_cmd == SRR_CMD_QEV_RD) |=> o_rsp_data == 16'h0000)
        else $error("events kept after clear");
    full_valid_a: assert property (o_err_full |-> o_err_valid)
        else $error("full queue empty");
endmodule : srr_status_regs_props

bind srr_status_regs srr_status_regs_props u_props (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_cmd_data(i_cmd_data), .i_serial_poll(i_serial_poll), .i_ovl_volt(i_ovl_volt),
    .i_ovl_curr(i_ovl_curr), .i_ovl_ohms(i_ovl_ohms), .i_lim_lo(i_lim_lo),
    .i_lim_hi(i_lim_hi), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
    .o_psc_wr(o_psc_wr), .o_psc_wr_data(o_psc_wr_data), .o_srq(o_srq),
    .o_err_valid(o_err_valid), .o_err_full(o_err_full));

// ===== verif/srr_status_regs_tb_top.sv
/*
 Self-checking bench of the status register block.
 Assumes the controller model and the bound checker; the bench plays the NV store.
*/
`timescale 1ns/1ps
module srr_status_regs_tb_top
    import srr_pkg::*;
;
    logic         i_mclk, i_reset, i_cmd_valid, i_psc_nv, i_limit_on, i_mav, i_serial_poll;
    logic         i_ovl_volt, i_ovl_curr, i_ovl_ohms, i_lim_lo, i_lim_hi, i_err_push, i_err_pop;
    logic         o_rsp_valid, o_psc_wr, o_psc_wr_data, o_srq, o_err_valid, o_err_full;
    srr_cmd_e     i_cmd;
    logic [15:0]  i_cmd_data, o_rsp_data;
    logic [7:0]   i_std_events, o_status_byte;
    logic [639:0] i_err_text, o_err_text;
    int           n_errors = 0;
    int           tests_run = 0;
    int           cycles = 0;
    logic [15:0]  wt [5] = '{16'h0001, 16'h0002, 16'h0200, 16'h0800, 16'h1000};

    srr_status_regs dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_cmd_valid(i_cmd_valid),
        .i_cmd(i_cmd), .i_cmd_data(i_cmd_data), .i_psc_nv(i_psc_nv), .i_ovl_volt(i_ovl_volt),
        .i_ovl_curr(i_ovl_curr), .i_ovl_ohms(i_ovl_ohms), .i_limit_on(i_limit_on),
        .i_lim_lo(i_lim_lo), .i_lim_hi(i_lim_hi), .i_std_events(i_std_events), .i_mav(i_mav),
        .i_serial_poll(i_serial_poll), .i_err_push(i_err_push), .i_err_text(i_err_text),
        .i_err_pop(i_err_pop), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
        .o_psc_wr(o_psc_wr), .o_psc_wr_data(o_psc_wr_data), .o_status_byte(o_status_byte),
        .o_srq(o_srq), .o_err_valid(o_err_valid), .o_err_text(o_err_text),
        .o_err_full(o_err_full));
    srr_ctl_model ctl (.i_mclk(i_mclk), .o_cmd(i_cmd), .o_cmd_valid(i_cmd_valid),
        .o_cmd_data(i_cmd_data));

    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    // Whole run needs about 200 cycles; the ceiling leaves ample slack
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task report_and_stop;
        if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task ask(input srr_cmd_e c, input logic [15:0] exp);
        ctl.send(c, 16'h0000);
        chk({c.name(), " strobe"}, 16'h0001, {15'h0000, o_rsp_valid});
        chk(c.name(), exp, o_rsp_data);
    endtask : ask
    task ev(input logic [4:0] v);
        @(negedge i_mclk);
        {i_ovl_volt, i_ovl_curr, i_ovl_ohms, i_lim_lo, i_lim_hi} = v;
        @(negedge i_mclk);
        {i_ovl_volt, i_ovl_curr, i_ovl_ohms, i_lim_lo, i_lim_hi} = 5'h00;
    endtask : ev
    task do_reset(input logic psc);
        i_psc_nv = psc;
        i_reset  = 1'b1;
        repeat (12) @(negedge i_mclk);
        i_reset = 1'b0;
        repeat (2) @(negedge i_mclk);
    endtask : do_reset
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_ques;
        i_limit_on = 1'b0;
        ev(5'h03);
        ask(SRR_CMD_QEV_RD, 16'h0000);
        i_limit_on = 1'b1;
        for (int i = 0; i < 5; i++) begin
            ev(5'h10 >> i);
            ask(SRR_CMD_QEV_RD, wt[i]);
        end
    endtask : t_ques
    task t_qen;
        ctl.send(SRR_CMD_QEN_WR, 16'hffff);
        ask(SRR_CMD_QEN_RD, 16'h1a03);
        ctl.send(SRR_CMD_PRESET, 16'h0000);
        ask(SRR_CMD_QEN_RD, 16'h0000);
        ctl.send(SRR_CMD_QEN_WR, 16'h0200);
        ctl.send(SRR_CMD_QEN_WR, 16'h0000);
        ask(SRR_CMD_QEN_RD, 16'h0000);
    endtask : t_qen
    task t_srq;
        ctl.send(SRR_CMD_QEN_WR, 16'h0001);
        ev(5'h10);
        ask(SRR_CMD_STB_RD, 16'h0008);
        ctl.send(SRR_CMD_SRE_WR, 16'h0008);
        ask(SRR_CMD_SRE_RD, 16'h0008);
        chk("srq", 16'h0001, {15'h0000, o_srq});
        ask(SRR_CMD_STB_RD, 16'h0048);
        chk("status byte", 16'h0048, {8'h00, o_status_byte});
        @(negedge i_mclk);
        i_serial_poll = 1'b1;
        @(negedge i_mclk);
        i_serial_poll = 1'b0;
        chk("srq poll", 16'h0000, {15'h0000, o_srq});
        ctl.send(SRR_CMD_CLS, 16'h0000);
        ask(SRR_CMD_QEV_RD, 16'h0000);
        ask(SRR_CMD_STB_RD, 16'h0000);
        ctl.send(SRR_CMD_SRE_WR, 16'h0000);
    endtask : t_srq
    task t_std;
        ctl.send(SRR_CMD_ESE_WR, 16'h0001);
        ask(SRR_CMD_ESE_RD, 16'h0001);
        ctl.send(SRR_CMD_OPC, 16'h0000);
        ask(SRR_CMD_ESR_RD, 16'h0001);
        @(negedge i_mclk);
        i_std_events = 8'hff;
        @(negedge i_mclk);
        i_std_events = 8'h00;
        i_mav        = 1'b1;
        ask(SRR_CMD_STB_RD, 16'h0030);
        i_mav = 1'b0;
        ask(SRR_CMD_ESR_RD, 16'h00bd);
        ask(SRR_CMD_OPC_RD, 16'h0001);
        ctl.send(SRR_CMD_ESE_WR, 16'h0000);
        ask(SRR_CMD_ESE_RD, 16'h0000);
    endtask : t_std
    task t_errq;
        for (int i = 0; i < 21; i++) begin
            @(negedge i_mclk);
            i_err_push = 1'b1;
            i_err_text = 640'(i + 1);
        end
        @(negedge i_mclk);
        i_err_push = 1'b0;
        chk("err full", 16'h0001, {15'h0000, o_err_full});
        ask(SRR_CMD_STB_RD, 16'h0004);
        for (int i = 0; i < 20; i++) begin
            chk("err valid", 16'h0001, {15'h0000, o_err_valid});
            @(negedge i_mclk);
            i_err_pop = 1'b1;
            @(negedge i_mclk);
            i_err_pop = 1'b0;
            chk("err text", 16'(i + 1), o_err_text[15:0]);
        end
        chk("err empty", 16'h0000, {15'h0000, o_err_valid});
    endtask : t_errq
    task t_psc;
        ctl.send(SRR_CMD_PSC_WR, 16'h0001);
        ask(SRR_CMD_PSC_RD, 16'h0001);
        ctl.send(SRR_CMD_ESE_WR, 16'h0020);
        ctl.send(SRR_CMD_QEN_WR, 16'h0001);
        do_reset(1'b1);
        ask(SRR_CMD_ESE_RD, 16'h0000);
        ask(SRR_CMD_QEN_RD, 16'h0000);
        ask(SRR_CMD_PSC_RD, 16'h0001);
        ctl.send(SRR_CMD_ESE_WR, 16'h0020);
        do_reset(1'b0);
        ask(SRR_CMD_ESE_RD, 16'h0020);
    endtask : t_psc

    initial begin
        {i_reset, i_psc_nv, i_limit_on, i_mav, i_serial_poll, i_err_push, i_err_pop} = 7'h00;
        {i_ovl_volt, i_ovl_curr, i_ovl_ohms, i_lim_lo, i_lim_hi} = 5'h00;
        i_std_events = 8'h00;
        i_err_text   = '0;
        do_reset(1'b1);
        t_ques();
        t_qen();
        t_srq();
        t_std();
        t_errq();
        t_psc();
        report_and_stop();
    end
endmodule : srr_status_regs_tb_top
